// >>> hdl/dcs_pkg.sv
// Package for the decoder CPU status register bank: map, field layout, sizes.
package dcs_pkg;

	// ------------------------------------------------------------
	// Read map offsets (4-bit CPU address)
	// ------------------------------------------------------------
	localparam logic [3:0] ADR_HEADER = 4'h0;
	localparam logic [3:0] ADR_SUBHEADER = 4'h1;
	localparam logic [3:0] ADR_HDR_FLAGS = 4'h2;
	localparam logic [3:0] ADR_MODE_FORM = 4'h3;
	localparam logic [3:0] ADR_DEC_STS = 4'h4;
	localparam logic [3:0] ADR_INT_STS = 4'h5;
	localparam logic [3:0] ADR_DMA_STS = 4'h6;
	localparam logic [3:0] ADR_BUF_RD_CMD = 4'hD;
	localparam logic [3:0] ADR_CMADR_PRM = 4'hE;
	localparam logic [3:0] ADR_CMADRH_HIF = 4'hF;

	// ------------------------------------------------------------
	// Write map offsets used by this block
	// ------------------------------------------------------------
	localparam logic [3:0] ADR_INT_CLEAR = 4'h4;
	localparam logic [3:0] ADR_BUF_WR_HIF = 4'hD;
	localparam logic [3:0] ADR_RESULT_WR = 4'hE;
	localparam logic [3:0] ADR_REG_ADDR = 4'hF;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BANK_BIT = 7;
	localparam int HIF_CLR_RESULT_BIT = 6;
	localparam int HIF_CLR_BUSY_BIT = 7;
	localparam int INT_HOST_CMD_BIT = 3;
	localparam int INT_RESULT_EMPTY_BIT = 5;
	localparam int NUM_INT = 7;
	localparam int NUM_HOST_IRQ = 3;

	// ------------------------------------------------------------
	// Sizes and reset values
	// ------------------------------------------------------------
	localparam int FIFO_DEPTH = 10;
	localparam logic [3:0] FIFO_LAST = 4'h9;
	localparam logic [3:0] FIFO_FULL_CNT = 4'hA;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] BYTE_IDX_LAST = 2'h3;

	// Per-sector decoder status flags, bit7 first
	typedef struct packed {
		logic check_parity_all_zero;
		logic erasure_seen;
		logic fix_inhibited;
		logic bytes_were_fixed;
		logic detect_code_ok;
		logic parity_correct_ok;
		logic short_sector;
		logic sync_missing;
	} dcs_dec_sts_s;

	// Mode/form result of the corrector plus the raw mode byte
	typedef struct packed {
		logic corrected_mode_bit;
		logic corrected_form_bit;
		logic [7:0] raw_mode_byte;
		logic raw_mode_erasure;
	} dcs_mode_in_s;

endpackage

// >>> hdl/dcs_status_regs.sv
// CPU read-side status register bank of the sector decoder with host FIFOs.
// Operation
// - Four reads of address 1 return the subheader bytes, file byte first.
// - Interrupt status shows raw conditions, independent of the mask register.
// - Interrupt bits 0..6: decoder, host DMA, overrun, command, reset, result, timeout.
// - Decoder status bit0 flags a missing sync mark replaced by an inserted sync.
// - Decoder status bit1 flags a short sector; such sectors skip ECC and EDC.
// - Decoder status bit2 means no errors remain through P parity; form 2 don't-care.
// - Decoder status bit3 is set when the EDC check finds no error.
// - Decoder status bit4 is set when at least one byte was corrected.
// - Decoder status bit5 flags mode byte error under auto detect; skip ECC and EDC.
// - Decoder status bit6 flags erasure pointer on any non-sync byte.
// - Decoder status bit7 flags error-free EDC parity bytes that are all zero.
// - Mode/form valid only in correction modes; bits 1,0 encode corrected format.
// - Mode/form bits 2..4: raw mode low bits, and OR of upper bits with pointer.
// - Write-ready rises when byte is stored or write DMA enabled; falls on write.
// - Read-ready rises when a fetched byte waits, falls when the CPU reads it.
// - DMA status bit2 shows read pointer bit; bit7 mirrors the bank select.
// - With read DMA enabled, each data read launches the next buffer read.
// - Host irq bits 0..2 set by CPU one-writes, cleared by host one-writes.
// - Host status bit3 means parameters readable, bit4 means parameter FIFO full.
// - In the 80-style host mode parameters come from a 10-byte FIFO.
// - Host status bit5 means result FIFO writable, bit6 means result FIFO empty.
// - Host status bit7 is busy: set by host command, cleared by CPU clear-busy.
// - Writing one to an interrupt clear bit clears that status; self-clearing.
// - Register address bit7 is the bank select for the 16-location map.
`timescale 1ns/1ns
module dcs_status_regs
	import dcs_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [3:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic [7:0] cpu_wdata_i,
	output logic [7:0] cpu_rdata_o,
	input wire logic sector_new_i,
	input wire logic [31:0] header_bytes_i,
	input wire logic [31:0] subheader_bytes_i,
	input wire logic [7:0] header_error_flags_i,
	input wire logic sector_done_i,
	input wire dcs_dec_sts_s dec_sts_i,
	input wire dcs_mode_in_s mode_in_i,
	input wire logic correction_mode_active_i,
	output logic fix_skip_o,
	input wire logic [NUM_INT-1:0] int_event_i,
	input wire logic [15:0] current_minute_addr_i,
	input wire logic cpu_dma_enable_i,
	input wire logic cpu_dma_direction_i,
	output logic buf_wr_req_o,
	output logic [7:0] buffer_write_data_o,
	input wire logic buf_wr_done_i,
	output logic buf_rd_req_o,
	input wire logic buf_rd_valid_i,
	input wire logic [7:0] buf_rd_data_i,
	input wire logic buf_rd_pointer_i,
	input wire logic host_style_select_i,
	input wire logic host_cmd_wr_i,
	input wire logic [7:0] host_cmd_data_i,
	input wire logic host_param_wr_i,
	input wire logic [7:0] host_param_data_i,
	input wire logic [NUM_HOST_IRQ-1:0] host_irq_clear_i,
	input wire logic host_result_rd_i,
	output logic [7:0] host_result_data_o,
	output logic [NUM_HOST_IRQ-1:0] host_irq_state_o,
	output logic host_busy_flag_o,
	output logic host_param_full_o,
	output logic host_result_empty_o
);
	// ------------------------------------------------------------
	// Helpers and state
	// ------------------------------------------------------------
	function automatic logic [3:0] fifo_next(input logic [3:0] p);
		fifo_next = (p == FIFO_LAST) ? 4'h0 : p + 4'h1;
	endfunction
	logic [7:0] rdata_ff;
	logic bank_select_bit_ff;
	logic [1:0] hdr_idx_ff;
	logic [1:0] sub_idx_ff;
	logic [7:0] hdr_flags_ff;
	dcs_dec_sts_s dec_sts_ff;
	dcs_mode_in_s mode_ff;
	logic [NUM_INT-1:0] int_sts_ff;
	logic buf_write_ready_ff;
	logic buf_read_ready_ff;
	logic buf_read_pointer_bit_ff;
	logic [7:0] buffer_read_data_ff;
	logic [7:0] bwdata_ff;
	logic bwreq_ff;
	logic [7:0] host_command_in_ff;
	logic host_busy_flag_ff;
	logic [NUM_HOST_IRQ-1:0] host_irq_state_ff;
	logic [7:0] host_result_ff;
	logic [7:0] prm_mem [FIFO_DEPTH];
	logic [3:0] prm_wp_ff, prm_rp_ff, prm_cnt_ff;
	logic [7:0] rsl_mem [FIFO_DEPTH];
	logic [3:0] rsl_wp_ff, rsl_rp_ff, rsl_cnt_ff;
	logic hmode_meta_ff, hmode_ff;
	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire host80 = ~hmode_ff;
	wire bank_h = bank_select_bit_ff;
	wire rd_hdr = cpu_rd_i && cpu_addr_i == ADR_HEADER;
	wire rd_sub = cpu_rd_i && cpu_addr_i == ADR_SUBHEADER;
	wire rd_bufdata = cpu_rd_i && cpu_addr_i == ADR_BUF_RD_CMD && !bank_h;
	wire rd_param = cpu_rd_i && cpu_addr_i == ADR_CMADR_PRM && bank_h && host80;
	wire wr_interrupt_clear_reg = cpu_wr_i && cpu_addr_i == ADR_INT_CLEAR;
	wire wr_bufdata = cpu_wr_i && cpu_addr_i == ADR_BUF_WR_HIF && !bank_h;
	wire wr_host_iface_control = cpu_wr_i && cpu_addr_i == ADR_BUF_WR_HIF && bank_h && host80;
	wire wr_result = cpu_wr_i && cpu_addr_i == ADR_RESULT_WR && bank_h && host80;
	wire wr_bank_select_bit = cpu_wr_i && cpu_addr_i == ADR_REG_ADDR;
	wire rd_dma_mode = cpu_dma_enable_i && !cpu_dma_direction_i;
	wire wr_dma_mode = cpu_dma_enable_i && cpu_dma_direction_i;
	// ------------------------------------------------------------
	// FIFO conditions
	// ------------------------------------------------------------
	wire prm_empty = prm_cnt_ff == 4'h0;
	wire prm_full = prm_cnt_ff == FIFO_FULL_CNT;
	wire prm_push = host_param_wr_i && host80 && !prm_full;
	wire prm_pop = rd_param && !prm_empty;
	wire rsl_empty = rsl_cnt_ff == 4'h0;
	wire rsl_full = rsl_cnt_ff == FIFO_FULL_CNT;
	wire rsl_clear = wr_host_iface_control && cpu_wdata_i[HIF_CLR_RESULT_BIT];
	wire rsl_push = wr_result && !rsl_full && !rsl_clear;
	wire rsl_pop = host_result_rd_i && host80 && !rsl_empty && !rsl_clear;
	wire rsl_drained = rsl_pop && rsl_cnt_ff == 4'h1;
	// ------------------------------------------------------------
	// Read data composition
	// ------------------------------------------------------------
	wire [7:0] mode_form_val = correction_mode_active_i ?
		{3'b000, mode_ff.raw_mode_erasure | (|mode_ff.raw_mode_byte[7:2]),
		 mode_ff.raw_mode_byte[1:0], mode_ff.corrected_mode_bit,
		 mode_ff.corrected_form_bit} : RESET_BYTE;
	wire [7:0] dma_sts_val = {bank_select_bit_ff, 4'h0, buf_read_pointer_bit_ff,
		buf_read_ready_ff, buf_write_ready_ff};
	wire [7:0] hif_sts_val = {host_busy_flag_ff, rsl_empty, !rsl_full, prm_full,
		!prm_empty, host_irq_state_ff};
	wire [7:0] hdr_byte = header_bytes_i[8*hdr_idx_ff +: 8];
	wire [7:0] sub_byte = subheader_bytes_i[8*sub_idx_ff +: 8];
	logic [7:0] nxt_rdata;
	always_comb begin
		case (cpu_addr_i)
			ADR_HEADER: nxt_rdata = hdr_byte;
			ADR_SUBHEADER: nxt_rdata = sub_byte;
			ADR_HDR_FLAGS: nxt_rdata = hdr_flags_ff;
			ADR_MODE_FORM: nxt_rdata = mode_form_val;
			ADR_DEC_STS: nxt_rdata = dec_sts_ff;
			ADR_INT_STS: nxt_rdata = {1'b0, int_sts_ff};
			ADR_DMA_STS: nxt_rdata = dma_sts_val;
			ADR_BUF_RD_CMD: nxt_rdata = bank_h ?
				(host80 ? host_command_in_ff : RESET_BYTE) : buffer_read_data_ff;
			ADR_CMADR_PRM: nxt_rdata = bank_h ?
				((host80 && !prm_empty) ? prm_mem[prm_rp_ff] : RESET_BYTE) :
				current_minute_addr_i[7:0];
			ADR_CMADRH_HIF: nxt_rdata = bank_h ?
				(host80 ? hif_sts_val : RESET_BYTE) : current_minute_addr_i[15:8];
			default: nxt_rdata = RESET_BYTE;
		endcase
	end
	// ------------------------------------------------------------
	// CPU read port and bank select
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_ff <= RESET_BYTE;
			bank_select_bit_ff <= 1'b0;
		end else begin
			if (cpu_rd_i) rdata_ff <= nxt_rdata;
			if (wr_bank_select_bit) bank_select_bit_ff <= cpu_wdata_i[BANK_BIT];
		end
	end
	// ------------------------------------------------------------
	// Header and subheader byte walkers
	// ------------------------------------------------------------
	// A new sector restarts both walks even mid-sequence
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hdr_idx_ff <= 2'h0;
			sub_idx_ff <= 2'h0;
		end else if (sector_new_i) begin
			hdr_idx_ff <= 2'h0;
			sub_idx_ff <= 2'h0;
		end else begin
			if (rd_hdr) hdr_idx_ff <= hdr_idx_ff + 2'h1;
			if (rd_sub) sub_idx_ff <= sub_idx_ff + 2'h1;
		end
	end
	// ------------------------------------------------------------
	// Per-sector decoder status capture
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			dec_sts_ff <= '0;
			mode_ff <= '0;
			hdr_flags_ff <= RESET_BYTE;
		end else if (sector_done_i) begin
			dec_sts_ff <= dec_sts_i;
			mode_ff <= mode_in_i;
			hdr_flags_ff <= header_error_flags_i;
		end
	end
	assign fix_skip_o = dec_sts_ff.short_sector | dec_sts_ff.fix_inhibited;
	// ------------------------------------------------------------
	// Interrupt status: raw sticky bits, set wins over clear
	// ------------------------------------------------------------
	logic [NUM_INT-1:0] int_set;
	always_comb begin
		int_set = int_event_i;
		int_set[INT_HOST_CMD_BIT] = int_event_i[INT_HOST_CMD_BIT] | host_cmd_wr_i;
		int_set[INT_RESULT_EMPTY_BIT] = int_event_i[INT_RESULT_EMPTY_BIT] | rsl_drained;
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) int_sts_ff <= '0;
		else int_sts_ff <= int_set |
			(int_sts_ff & ~(wr_interrupt_clear_reg ? cpu_wdata_i[NUM_INT-1:0] : '0));
	end
	// ------------------------------------------------------------
	// CPU buffer port
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			buf_write_ready_ff <= 1'b0;
			buf_read_ready_ff <= 1'b0;
			buf_read_pointer_bit_ff <= 1'b0;
			buffer_read_data_ff <= RESET_BYTE;
			bwdata_ff <= RESET_BYTE;
			bwreq_ff <= 1'b0;
		end else begin
			bwreq_ff <= wr_bufdata;
			if (wr_bufdata) bwdata_ff <= cpu_wdata_i;
			if (buf_wr_done_i || wr_dma_mode) buf_write_ready_ff <= 1'b1;
			else if (wr_bufdata) buf_write_ready_ff <= 1'b0;
			if (buf_rd_valid_i) begin
				buf_read_ready_ff <= 1'b1;
				buffer_read_data_ff <= buf_rd_data_i;
				buf_read_pointer_bit_ff <= buf_rd_pointer_i;
			end else if (rd_bufdata) begin
				buf_read_ready_ff <= 1'b0;
			end
		end
	end
	assign buf_wr_req_o = bwreq_ff;
	assign buffer_write_data_o = bwdata_ff;
	// Combinational so the next fetch starts in the read cycle itself
	assign buf_rd_req_o = rd_bufdata && rd_dma_mode;
	// ------------------------------------------------------------
	// Host command, busy and host interrupt state
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			host_command_in_ff <= RESET_BYTE;
			host_busy_flag_ff <= 1'b0;
			host_irq_state_ff <= '0;
		end else begin
			if (host_cmd_wr_i) host_command_in_ff <= host_cmd_data_i;
			if (host_cmd_wr_i) host_busy_flag_ff <= 1'b1;
			else if (wr_host_iface_control && cpu_wdata_i[HIF_CLR_BUSY_BIT]) host_busy_flag_ff <= 1'b0;
			host_irq_state_ff <= (wr_host_iface_control ? cpu_wdata_i[NUM_HOST_IRQ-1:0] : '0) |
				(host_irq_state_ff & ~host_irq_clear_i);
		end
	end
	assign host_irq_state_o = host_irq_state_ff;
	assign host_busy_flag_o = host_busy_flag_ff;
	// ------------------------------------------------------------
	// Host mode pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hmode_meta_ff <= 1'b0;
			hmode_ff <= 1'b0;
		end else begin
			hmode_meta_ff <= host_style_select_i;
			hmode_ff <= hmode_meta_ff;
		end
	end
	// ------------------------------------------------------------
	// Parameter FIFO: host fills, CPU drains
	// ------------------------------------------------------------
	// Pushes into a full FIFO are dropped; the host must watch the full flag
	always_ff @(posedge clk_i) begin
		if (prm_push) prm_mem[prm_wp_ff] <= host_param_data_i;
		if (rsl_push) rsl_mem[rsl_wp_ff] <= cpu_wdata_i;
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prm_wp_ff <= 4'h0;
			prm_rp_ff <= 4'h0;
			prm_cnt_ff <= 4'h0;
		end else begin
			if (prm_push) prm_wp_ff <= fifo_next(prm_wp_ff);
			if (prm_pop) prm_rp_ff <= fifo_next(prm_rp_ff);
			prm_cnt_ff <= prm_cnt_ff + {3'b000, prm_push} - {3'b000, prm_pop};
		end
	end
	assign host_param_full_o = prm_full;
	// ------------------------------------------------------------
	// Result FIFO: CPU fills, host drains
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rsl_wp_ff <= 4'h0;
			rsl_rp_ff <= 4'h0;
			rsl_cnt_ff <= 4'h0;
			host_result_ff <= RESET_BYTE;
		end else if (rsl_clear) begin
			rsl_wp_ff <= 4'h0;
			rsl_rp_ff <= 4'h0;
			rsl_cnt_ff <= 4'h0;
		end else begin
			if (rsl_push) rsl_wp_ff <= fifo_next(rsl_wp_ff);
			if (rsl_pop) begin
				rsl_rp_ff <= fifo_next(rsl_rp_ff);
				host_result_ff <= rsl_mem[rsl_rp_ff];
			end
			rsl_cnt_ff <= rsl_cnt_ff + {3'b000, rsl_push} - {3'b000, rsl_pop};
		end
	end
	assign host_result_data_o = host_result_ff;
	assign host_result_empty_o = rsl_empty;
	assign cpu_rdata_o = rdata_ff;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_sub_first_read;
		rd_sub && sub_idx_ff == 2'h0 && !sector_new_i;
	endsequence
	sequence s_sub_second_read;
		rd_sub && sub_idx_ff == 2'h1 && !sector_new_i;
	endsequence
	chk_sub_file_first: assert property (s_sub_first_read |=>
		cpu_rdata_o == $past(subheader_bytes_i[7:0]) && sub_idx_ff == 2'h1)
		else $error("subheader walk does not start at file byte");
	chk_sub_walk_order: assert property (s_sub_second_read |=>
		cpu_rdata_o == $past(subheader_bytes_i[15:8]) && sub_idx_ff == 2'h2)
		else $error("subheader second byte out of order");
	chk_int_raw_set: assert property (int_event_i[0] |=> int_sts_ff[0])
		else $error("raw interrupt event lost");
	chk_int_clear_bit: assert property (wr_interrupt_clear_reg && cpu_wdata_i[6] && !int_event_i[6]
		|=> !int_sts_ff[6])
		else $error("interrupt clear had no effect");
	chk_rd_ready_flow: assert property (buf_rd_valid_i |=> buf_read_ready_ff
		&& buffer_read_data_ff == $past(buf_rd_data_i))
		else $error("fetched byte not held as ready");
	chk_rd_ready_drop: assert property (rd_bufdata && !buf_rd_valid_i |=> !buf_read_ready_ff)
		else $error("read ready did not fall on read");
	chk_rd_launch_req: assert property (cpu_rd_i && cpu_addr_i == ADR_BUF_RD_CMD
		&& !bank_select_bit_ff && cpu_dma_enable_i && !cpu_dma_direction_i |-> buf_rd_req_o)
		else $error("buffer read not launched");
	chk_wr_ready_drop: assert property (wr_bufdata && !buf_wr_done_i && !wr_dma_mode
		|=> !buf_write_ready_ff && buf_wr_req_o)
		else $error("write ready did not fall on write");
	chk_busy_set: assert property (host_cmd_wr_i |=> host_busy_flag_o && int_sts_ff[3])
		else $error("host command did not set busy");
	chk_param_full: assert property (prm_full && !prm_pop |=> host_param_full_o
		&& hif_sts_val[4] && hif_sts_val[3])
		else $error("parameter full flag wrong");
	chk_host_irq_set: assert property (wr_host_iface_control && cpu_wdata_i[0] |=> host_irq_state_o[0])
		else $error("host irq bit not set");
	chk_bank_mirror: assert property (wr_bank_select_bit |=>
		dma_sts_val[7] == $past(cpu_wdata_i[7]))
		else $error("bank select not mirrored");

endmodule

// >>> testbench/dcs_buf_model.sv
// Behavioural buffer memory on the far side of the CPU buffer port.
`timescale 1ns/1ns
module dcs_buf_model (
	input wire logic clk_i,
	input wire logic [4:0] lat_i,
	input wire logic wr_req_i,
	input wire logic [7:0] wr_data_i,
	output logic wr_done_o,
	input wire logic rd_req_i,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	output logic rd_ptr_o
);
	logic [7:0] mem [16];
	logic [3:0] wp = 4'h0;
	logic [3:0] rp = 4'h0;
	logic [4:0] wcnt = 5'h00;
	logic [4:0] rcnt = 5'h00;

	initial {wr_done_o, rd_valid_o, rd_data_o, rd_ptr_o} = '0;

	// ------------------------------------------------------------
	// Latency counters on the rising edge, answers on the falling edge
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (wr_req_i) begin
			mem[wp] <= wr_data_i;
			wp <= wp + 4'h1;
			wcnt <= lat_i;
		end else if (wcnt != 5'h00) begin
			wcnt <= wcnt - 5'h01;
		end
		if (rd_req_i) begin
			rcnt <= lat_i;
		end else if (rcnt != 5'h00) begin
			rcnt <= rcnt - 5'h01;
		end
	end

	always @(negedge clk_i) begin
		wr_done_o <= (wcnt == 5'h01);
		rd_valid_o <= (rcnt == 5'h01);
		if (rcnt == 5'h01) begin
			rd_data_o <= mem[rp];
			rd_ptr_o <= rp[0];
			rp <= rp + 4'h1;
		end else begin
			// Lines toggle between fetches so a design that samples them late is caught
			rd_data_o <= ~rd_data_o;
			rd_ptr_o <= ~rd_ptr_o;
		end
	end
endmodule

// >>> testbench/dcs_status_regs_tb.sv
// Self-checking bench for the decoder CPU status register bank.
`timescale 1ns/1ns
module dcs_status_regs_tb
	import dcs_pkg::*;
;
	logic clk_i, reset_i, cpu_rd_i, cpu_wr_i, sector_new_i, sector_done_i;
	logic correction_mode_active_i, cpu_dma_enable_i, cpu_dma_direction_i, host_style_select_i;
	logic host_cmd_wr_i, host_param_wr_i, host_result_rd_i, buf_wr_done_i, buf_rd_valid_i;
	logic buf_rd_pointer_i, fix_skip_o, buf_wr_req_o, buf_rd_req_o, host_busy_flag_o;
	logic host_param_full_o, host_result_empty_o;
	logic [3:0] cpu_addr_i;
	logic [7:0] cpu_wdata_i, cpu_rdata_o, header_error_flags_i, buffer_write_data_o;
	logic [7:0] buf_rd_data_i, host_cmd_data_i, host_param_data_i, host_result_data_o;
	logic [31:0] header_bytes_i, subheader_bytes_i;
	logic [15:0] current_minute_addr_i;
	logic [NUM_INT-1:0] int_event_i;
	logic [NUM_HOST_IRQ-1:0] host_irq_clear_i, host_irq_state_o;
	dcs_dec_sts_s dec_sts_i;
	dcs_mode_in_s mode_in_i;
	logic [4:0] lat;
	logic [10:0] mdi [4] = '{11'h48C, 11'h603, 11'h004, 11'h48C};
	logic [7:0] mdo [4] = '{8'h1A, 8'h17, 8'h08, 8'h00};
	int i;
	int n_fail = 0;
	int cmp_count = 0;

	dcs_status_regs dut (.clk_i, .reset_i, .cpu_addr_i, .cpu_rd_i, .cpu_wr_i, .cpu_wdata_i,
		.cpu_rdata_o, .sector_new_i, .header_bytes_i, .subheader_bytes_i, .header_error_flags_i,
		.sector_done_i, .dec_sts_i, .mode_in_i, .correction_mode_active_i, .fix_skip_o,
		.int_event_i, .current_minute_addr_i, .cpu_dma_enable_i, .cpu_dma_direction_i,
		.buf_wr_req_o, .buffer_write_data_o, .buf_wr_done_i, .buf_rd_req_o, .buf_rd_valid_i,
		.buf_rd_data_i, .buf_rd_pointer_i, .host_style_select_i, .host_cmd_wr_i,
		.host_cmd_data_i, .host_param_wr_i, .host_param_data_i, .host_irq_clear_i,
		.host_result_rd_i, .host_result_data_o, .host_irq_state_o, .host_busy_flag_o,
		.host_param_full_o, .host_result_empty_o);

	dcs_buf_model mem_side (.clk_i(clk_i), .lat_i(lat), .wr_req_i(buf_wr_req_o),
		.wr_data_i(buffer_write_data_o), .wr_done_o(buf_wr_done_i), .rd_req_i(buf_rd_req_o),
		.rd_valid_o(buf_rd_valid_i), .rd_data_o(buf_rd_data_i), .rd_ptr_o(buf_rd_pointer_i));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", w, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk_i);
		cpu_addr_i = a;
		cpu_rd_i = 1'b1;
		@(negedge clk_i);
		cpu_rd_i = 1'b0;
		@(negedge clk_i);
		d = cpu_rdata_o;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string w);
		logic [7:0] d;
		rd(a, d);
		chk(w, d, e);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(negedge clk_i);
		cpu_addr_i = a;
		cpu_wdata_i = v;
		cpu_wr_i = 1'b1;
		@(negedge clk_i);
		cpu_wr_i = 1'b0;
	endtask
	task automatic pls(ref logic s);
		@(negedge clk_i);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
	endtask
	// Bounded wait on a DMA status flag; running out ends the run
	task automatic poll(input int b);
		logic [7:0] d;
		int n;
		d = 8'h00;
		for (n = 0; n < 40 && d[b] !== 1'b1; n++) rd(ADR_DMA_STS, d);
		if (d[b] !== 1'b1) begin
			n_fail++;
			$display("unexpected dma_ready exp 1 seen 0");
			test_done();
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		reset_i = 1'b1;
		{cpu_rd_i, cpu_wr_i, sector_new_i, sector_done_i, correction_mode_active_i} = '0;
		{cpu_dma_enable_i, cpu_dma_direction_i, host_style_select_i, host_cmd_wr_i} = '0;
		{host_param_wr_i, host_result_rd_i, host_irq_clear_i, int_event_i, cpu_addr_i} = '0;
		{cpu_wdata_i, header_error_flags_i, host_cmd_data_i, host_param_data_i} = '0;
		{dec_sts_i, mode_in_i} = '0;
		header_bytes_i = 32'hD4C3B2A1;
		subheader_bytes_i = 32'h44332211;
		current_minute_addr_i = 16'hBEEF;
		lat = 5'h03;
		repeat (5) @(negedge clk_i);
		reset_i = 1'b0;
		for (i = 2; i < 7; i++) rdc(4'(i), 8'h00, "reset");
		rdc(ADR_CMADR_PRM, 8'hEF, "cmadr_lo");
		rdc(ADR_CMADRH_HIF, 8'hBE, "cmadr_hi");
		rdc(4'h8, 8'h00, "unmapped");
		wr(ADR_REG_ADDR, 8'h80);
		rdc(ADR_DMA_STS, 8'h80, "bank");
		rdc(ADR_CMADRH_HIF, 8'h60, "hif_reset");
		$display("test reset done");
		host_cmd_data_i = 8'h5A;
		pls(host_cmd_wr_i);
		rdc(ADR_BUF_RD_CMD, 8'h5A, "host_cmd");
		rdc(ADR_CMADRH_HIF, 8'hE0, "busy_set");
		wr(ADR_BUF_WR_HIF, 8'h85);
		rdc(ADR_CMADRH_HIF, 8'h65, "irq_set");
		chk("busy_pin", {7'h00, host_busy_flag_o}, 8'h00);
		@(negedge clk_i);
		host_irq_clear_i = 3'h1;
		@(negedge clk_i);
		host_irq_clear_i = 3'h0;
		chk("irq_state", {5'h00, host_irq_state_o}, 8'h04);
		for (i = 0; i <= FIFO_DEPTH; i++) begin
			host_param_data_i = 8'(8'h30 + i);
			pls(host_param_wr_i);
		end
		rdc(ADR_CMADRH_HIF, 8'h7C, "prm_full");
		chk("prm_full_pin", {7'h00, host_param_full_o}, 8'h01);
		for (i = 0; i < FIFO_DEPTH; i++) rdc(ADR_CMADR_PRM, 8'(8'h30 + i), "param");
		rdc(ADR_CMADRH_HIF, 8'h64, "prm_empty");
		for (i = 0; i <= FIFO_DEPTH; i++) wr(ADR_RESULT_WR, 8'(8'hA0 + i));
		rdc(ADR_CMADRH_HIF, 8'h04, "rsl_full");
		for (i = 0; i < FIFO_DEPTH; i++) begin
			pls(host_result_rd_i);
			chk("result", host_result_data_o, 8'(8'hA0 + i));
		end
		chk("rsl_empty", {7'h00, host_result_empty_o}, 8'h01);
		rdc(ADR_INT_STS, 8'h28, "drained");
		wr(ADR_INT_CLEAR, 8'h28);
		wr(ADR_RESULT_WR, 8'h11);
		wr(ADR_BUF_WR_HIF, 8'h40);
		rdc(ADR_CMADRH_HIF, 8'h64, "rsl_clear");
		// Host registers vanish once the synchronised mode pin leaves 80-style
		host_style_select_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rdc(ADR_CMADRH_HIF, 8'h00, "hif_off");
		rdc(ADR_BUF_RD_CMD, 8'h00, "cmd_off");
		host_style_select_i = 1'b0;
		repeat (2) @(negedge clk_i);
		wr(ADR_REG_ADDR, 8'h00);
		$display("test host done");
		pls(sector_new_i);
		for (i = 0; i < 5; i++) begin
			rdc(ADR_HEADER, header_bytes_i[8*(i%4) +: 8], "header");
			rdc(ADR_SUBHEADER, subheader_bytes_i[8*(i%4) +: 8], "subhdr");
		end
		for (i = 0; i < 8; i++) begin
			dec_sts_i = dcs_dec_sts_s'(8'h01 << i);
			header_error_flags_i = 8'h80 >> i;
			pls(sector_done_i);
			rdc(ADR_DEC_STS, 8'h01 << i, "dec_sts");
			rdc(ADR_HDR_FLAGS, 8'h80 >> i, "hdr_flags");
			chk("fix_skip", {7'h00, fix_skip_o}, {7'h00, i == 1 || i == 5});
		end
		for (i = 0; i < 4; i++) begin
			mode_in_i = mdi[i];
			correction_mode_active_i = (i != 3);
			pls(sector_done_i);
			rdc(ADR_MODE_FORM, mdo[i], "mode_form");
		end
		$display("test sector done");
		wr(4'h3, 8'h7F);
		for (i = 0; i < NUM_INT; i++) begin
			@(negedge clk_i);
			int_event_i = 7'h01 << i;
			@(negedge clk_i);
			int_event_i = '0;
			rdc(ADR_INT_STS, 8'h01 << i, "int_sts");
			wr(ADR_INT_CLEAR, 8'h01 << i);
			rdc(ADR_INT_STS, 8'h00, "int_clr");
		end
		$display("test interrupt done");
		lat = 5'h14;
		wr(ADR_BUF_WR_HIF, 8'h3C);
		rdc(ADR_DMA_STS, 8'h00, "wr_pending");
		poll(0);
		lat = 5'h01;
		wr(ADR_BUF_WR_HIF, 8'hC3);
		poll(0);
		lat = 5'h06;
		cpu_dma_enable_i = 1'b1;
		rdc(ADR_BUF_RD_CMD, 8'h00, "rd_stale");
		poll(1);
		rdc(ADR_DMA_STS, 8'h03, "rd_ready");
		rdc(ADR_BUF_RD_CMD, 8'h3C, "rd_data0");
		rdc(ADR_DMA_STS, 8'h01, "rd_taken");
		poll(1);
		rdc(ADR_DMA_STS, 8'h07, "rd_ptr");
		cpu_dma_enable_i = 1'b0;
		rdc(ADR_BUF_RD_CMD, 8'hC3, "rd_data1");
		lat = 5'h14;
		wr(ADR_BUF_WR_HIF, 8'h11);
		rdc(ADR_DMA_STS, 8'h04, "wr_busy");
		{cpu_dma_enable_i, cpu_dma_direction_i} = 2'h3;
		rdc(ADR_DMA_STS, 8'h05, "wr_dma");
		$display("test buffer done");
		test_done();
	end
endmodule
